// File: logic/fault_status_pkg.sv
package fault_status_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] FAULT_EVENT_FLAGS_ADDR = 8'h03;
  localparam logic [7:0] FLAGS_RESET            = 8'h20;
  // ==========================================================
  // Field positions
  localparam int BIT_FAULT_STATE = 7;
  localparam int BIT_DISCH_FAIL  = 6;
  localparam int BIT_POWERUP     = 5;
  localparam int BIT_VBUS_LOW    = 4;
  localparam int BIT_OVERTEMP    = 3;
  localparam int BIT_OVERVOLT    = 2;
  localparam int NUM_COND        = 4;
endpackage : fault_status_pkg

// File: logic/cond_flag.sv
module cond_flag
  import fault_status_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic cond_in,
  input  wire logic read_clr_in,
  input  wire logic fault_clr_in,
  output logic      flag_out
);
  typedef struct packed {
    logic flag;
  } cflag_state_t;

  cflag_state_t state_q;
  cflag_state_t state_d;

  // ==========================================================
  // Sticky flag; condition wins over any clear
  always_comb
  begin
    state_d = state_q;
    if (read_clr_in && !cond_in)
      state_d.flag = 1'b0;
    if (fault_clr_in)
      state_d.flag = 1'b0;
    if (cond_in)
      state_d.flag = 1'b1;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign flag_out = state_q.flag;

  a_cond_sets_flag: assert property ( // see [RULE6]
    @(posedge clk_in) disable iff (!resetn_in)
    cond_in |=> flag_out)
    else $error("flag not set by condition");
  a_read_clears: assert property ( // see [RULE7]
    @(posedge clk_in) disable iff (!resetn_in)
    (read_clr_in && !cond_in) |=> !flag_out)
    else $error("flag kept after clean read");
  a_fault_clears: assert property ( // see [RULE7]
    @(posedge clk_in) disable iff (!resetn_in)
    (fault_clr_in && !cond_in) |=> !flag_out)
    else $error("flag kept after fault clear");
endmodule : cond_flag

// File: logic/port1_fault_status_logic.sv
// Functional notes
// [RULE1] Writing fault bit zero rechecks, clears if clean
// [RULE2] Stay in error while another flag set
// [RULE3] Auto recovery clears fault bit when clean
// [RULE4] Port power disable clears fault bit
// [RULE5] Bit 7 mirrors error state, set on entry
// [RULE6] Discharge failure sets bit 6, alert, error
// [RULE7] Bit 6 clears on clean read or fault clear
// [RULE8] Bit 5 set at powerup, clears read/toggle
// [RULE9] Powerup bit no alert, kept in sleep
// [RULE10] Vbus low sets bit 4, alert, error
// [RULE11] Overtemp sets bit 3, error, clear rules
// [RULE12] Overtemp asserts both alert outputs
// [RULE13] Overvoltage sets bit 2, both alerts, error
// [RULE14] Read clear only touches bits returned
module port1_fault_status_logic
  import fault_status_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_rd_in,
  input  wire logic       reg_rd_done_in,
  input  wire logic       auto_recover_in,
  input  wire logic       port1_power_enable_in,
  input  wire logic       power_enable_control_in,
  input  wire logic       discharge_fail_in,
  input  wire logic       vbus_low_in,
  input  wire logic       overtemp_in,
  input  wire logic       overvolt_in,
  output logic [7:0]      reg_rdata_out,
  output logic            port1_fault_state_out,
  output logic            alert1_n_out,
  output logic            alert2_n_out
);
  typedef enum logic {ST_ACTIVE, ST_ERROR} port_state_t;

  typedef struct packed {
    port_state_t st;
    logic        powerup;
    logic [7:0]  rdata;
    logic [NUM_COND-1:0] snap;
    logic        pen_last;
    logic        pen_seen;
    logic        rd_hit;
    logic        alert1_n;
    logic        alert2_n;
  } top_state_t;

  top_state_t state_q;
  top_state_t state_d;

  logic [NUM_COND-1:0] cond;
  logic [NUM_COND-1:0] flags;
  logic [NUM_COND-1:0] rd_clr;
  logic                fault_clr;
  logic                wr_clr;
  logic                addr_hit;
  logic                any_cond;
  logic                any_flag;
  logic                pen_toggle;

  assign addr_hit = reg_addr_in == FAULT_EVENT_FLAGS_ADDR;
  assign cond = {discharge_fail_in, vbus_low_in, overtemp_in, overvolt_in};
  assign any_cond = |cond;
  assign any_flag = |flags;
  assign wr_clr = reg_wr_in && addr_hit
                  && !reg_wdata_in[BIT_FAULT_STATE];
  // Armed after reset so a high idle level is no false toggle
  assign pen_toggle = state_q.pen_seen
                      && (power_enable_control_in != state_q.pen_last);
  // Clear by leaving error: port disable or accepted recovery
  assign fault_clr = (state_q.st == ST_ERROR) && (state_d.st == ST_ACTIVE);
  // Only snapshot bits of the finished read are cleared
  assign rd_clr = (reg_rd_done_in && state_q.rd_hit)
                  ? state_q.snap : '0; // see [RULE14]

  // ==========================================================
  // Condition flags, bits 6 and 4 down to 2
  genvar gi;
  generate
    for (gi = 0; gi < NUM_COND; gi++)
    begin : g_flag
      cond_flag u_flag (
        .clk_in       (clk_in),
        .resetn_in    (resetn_in),
        .cond_in      (cond[gi]),
        .read_clr_in  (rd_clr[gi]), // see [RULE7] [RULE10] [RULE11]
        .fault_clr_in (fault_clr), // see [RULE13]
        .flag_out     (flags[gi])
      );
      a_unread_kept: assert property ( // see [RULE14]
        @(posedge clk_in) disable iff (!resetn_in)
        (reg_rd_done_in && flags[gi] && !state_q.snap[gi] && !fault_clr)
        |=> flags[gi])
        else $error("unread flag lost");
    end
  endgenerate

  // ==========================================================
  // State machine and register
  always_comb
  begin
    state_d = state_q;
    state_d.pen_last = power_enable_control_in;
    state_d.pen_seen = 1'b1;
    unique case (state_q.st)
      ST_ACTIVE:
      begin
        // A disabled port never enters the error state
        if (any_cond && port1_power_enable_in) // see [RULE6] [RULE10]
          state_d.st = ST_ERROR; // see [RULE11] [RULE13]
      end
      ST_ERROR:
      begin
        if (!port1_power_enable_in) // see [RULE4]
          state_d.st = ST_ACTIVE;
        else if ((wr_clr || auto_recover_in) // see [RULE1] [RULE3]
                 && !any_cond && !any_flag // see [RULE2]
                 && !state_q.powerup)
          state_d.st = ST_ACTIVE;
      end
    endcase
    // Only a finished read of this register may clear bits
    if (reg_rd_done_in)
      state_d.rd_hit = 1'b0;
    if (reg_rd_in)
      state_d.rd_hit = addr_hit;
    if (reg_rd_in && addr_hit)
    begin
      state_d.rdata = {state_q.st == ST_ERROR, flags[3], state_q.powerup,
                       flags[2], flags[1], flags[0], 2'b00}; // see [RULE5]
      state_d.snap = flags;
    end
    // Powerup bit survives sleep; only read or enable toggle clear it
    if ((reg_rd_done_in && state_q.rd_hit && state_q.rdata[BIT_POWERUP])
        || pen_toggle)
      state_d.powerup = 1'b0; // see [RULE8]
    // Alerts ignore the powerup bit
    state_d.alert1_n = !(any_flag || any_cond); // see [RULE9]
    state_d.alert2_n = !(flags[1] || flags[0]
                         || overtemp_in || overvolt_in); // see [RULE12]
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_q          <= '0;
      state_q.st       <= ST_ACTIVE;
      state_q.powerup  <= 1'b1;
      state_q.alert1_n <= 1'b1;
      state_q.alert2_n <= 1'b1;
      state_q.rdata    <= FLAGS_RESET;
    end
    else
      state_q <= state_d;
  end

  assign reg_rdata_out         = state_q.rdata;
  assign port1_fault_state_out = state_q.st == ST_ERROR;
  assign alert1_n_out          = state_q.alert1_n;
  assign alert2_n_out          = state_q.alert2_n;

  // ==========================================================
  // Checks
  a_stay_in_error: assert property ( // see [RULE2]
    @(posedge clk_in) disable iff (!resetn_in)
    (state_q.st == ST_ERROR && port1_power_enable_in
     && (any_flag || state_q.powerup))
    |=> state_q.st == ST_ERROR)
    else $error("left error with flag set");
  a_disable_clears: assert property ( // see [RULE4]
    @(posedge clk_in) disable iff (!resetn_in)
    !port1_power_enable_in
    |=> !port1_fault_state_out)
    else $error("fault bit kept with port disabled");
  a_error_entry: assert property ( // see [RULE6]
    @(posedge clk_in) disable iff (!resetn_in)
    (any_cond && port1_power_enable_in)
    |=> port1_fault_state_out)
    else $error("error state not entered");
  a_vbus_error: assert property ( // see [RULE10]
    @(posedge clk_in) disable iff (!resetn_in)
    (vbus_low_in && port1_power_enable_in)
    |=> port1_fault_state_out)
    else $error("vbus low did not enter error");
  a_temp_error: assert property ( // see [RULE11]
    @(posedge clk_in) disable iff (!resetn_in)
    (overtemp_in && port1_power_enable_in)
    |=> port1_fault_state_out)
    else $error("overtemp did not enter error");
  a_volt_error: assert property ( // see [RULE13]
    @(posedge clk_in) disable iff (!resetn_in)
    (overvolt_in && port1_power_enable_in)
    |=> port1_fault_state_out)
    else $error("overvolt did not enter error");
  a_alert1_event: assert property ( // see [RULE10]
    @(posedge clk_in) disable iff (!resetn_in)
    (vbus_low_in || discharge_fail_in)
    |=> !alert1_n_out)
    else $error("alert1 missing");
  a_overtemp_both: assert property ( // see [RULE12]
    @(posedge clk_in) disable iff (!resetn_in)
    overtemp_in
    |=> (!alert1_n_out && !alert2_n_out))
    else $error("overtemp alerts missing");
  a_overvolt_both: assert property ( // see [RULE13]
    @(posedge clk_in) disable iff (!resetn_in)
    overvolt_in
    |=> (!alert1_n_out && !alert2_n_out))
    else $error("overvolt alerts missing");
  a_alert2_clean: assert property ( // see [RULE12]
    @(posedge clk_in) disable iff (!resetn_in)
    (!flags[1] && !flags[0] && !overtemp_in && !overvolt_in)
    |=> alert2_n_out)
    else $error("alert2 without cause");
  a_powerup_toggle: assert property ( // see [RULE8]
    @(posedge clk_in) disable iff (!resetn_in)
    pen_toggle
    |=> !state_q.powerup)
    else $error("powerup bit not cleared");
  a_powerup_read_clr: assert property ( // see [RULE8]
    @(posedge clk_in) disable iff (!resetn_in)
    (reg_rd_done_in && state_q.rd_hit && state_q.rdata[BIT_POWERUP])
    |=> !state_q.powerup)
    else $error("powerup bit kept after read");
  a_powerup_kept: assert property ( // see [RULE9]
    @(posedge clk_in) disable iff (!resetn_in)
    (state_q.powerup && !pen_toggle && !(reg_rd_done_in && state_q.rd_hit))
    |=> state_q.powerup)
    else $error("powerup bit lost");
  a_noalert_clean: assert property ( // see [RULE9]
    @(posedge clk_in) disable iff (!resetn_in)
    (!any_flag && !any_cond)
    |=> alert1_n_out)
    else $error("alert without cause");
  a_noalert_powerup: assert property ( // see [RULE9]
    @(posedge clk_in) disable iff (!resetn_in)
    (state_q.powerup && !any_flag && !any_cond)
    |=> (alert1_n_out && alert2_n_out))
    else $error("alert from powerup bit");
  a_auto_recover: assert property ( // see [RULE3]
    @(posedge clk_in) disable iff (!resetn_in)
    (auto_recover_in && !any_cond && !any_flag && !state_q.powerup)
    |=> !port1_fault_state_out)
    else $error("auto recovery failed");
  a_write_recover: assert property ( // see [RULE1]
    @(posedge clk_in) disable iff (!resetn_in)
    (wr_clr && !any_cond && !any_flag && !state_q.powerup)
    |=> !port1_fault_state_out)
    else $error("recovery write ignored");
  a_write_refused: assert property ( // see [RULE1]
    @(posedge clk_in) disable iff (!resetn_in)
    (state_q.st == ST_ERROR && port1_power_enable_in && wr_clr && any_cond)
    |=> port1_fault_state_out)
    else $error("recovery taken with condition");
  a_fault_bit_set: assert property ( // see [RULE5]
    @(posedge clk_in) disable iff (!resetn_in)
    (reg_rd_in && addr_hit && state_q.st == ST_ERROR)
    |=> reg_rdata_out[BIT_FAULT_STATE])
    else $error("fault bit reads zero in error");
  a_fault_bit_clear: assert property ( // see [RULE5]
    @(posedge clk_in) disable iff (!resetn_in)
    (reg_rd_in && addr_hit && state_q.st == ST_ACTIVE)
    |=> !reg_rdata_out[BIT_FAULT_STATE])
    else $error("fault bit reads one in active");
  a_disch_bit_read: assert property ( // see [RULE6]
    @(posedge clk_in) disable iff (!resetn_in)
    (reg_rd_in && addr_hit && flags[3])
    |=> reg_rdata_out[BIT_DISCH_FAIL])
    else $error("discharge bit not returned");
  a_powerup_bit_read: assert property ( // see [RULE8]
    @(posedge clk_in) disable iff (!resetn_in)
    (reg_rd_in && addr_hit && state_q.powerup)
    |=> reg_rdata_out[BIT_POWERUP])
    else $error("powerup bit not returned");
  a_vbus_bit_read: assert property ( // see [RULE10]
    @(posedge clk_in) disable iff (!resetn_in)
    (reg_rd_in && addr_hit && flags[2])
    |=> reg_rdata_out[BIT_VBUS_LOW])
    else $error("vbus low bit not returned");
  a_temp_bit_read: assert property ( // see [RULE11]
    @(posedge clk_in) disable iff (!resetn_in)
    (reg_rd_in && addr_hit && flags[1])
    |=> reg_rdata_out[BIT_OVERTEMP])
    else $error("overtemp bit not returned");
  a_volt_bit_read: assert property ( // see [RULE13]
    @(posedge clk_in) disable iff (!resetn_in)
    (reg_rd_in && addr_hit && flags[0])
    |=> reg_rdata_out[BIT_OVERVOLT])
    else $error("overvolt bit not returned");
  a_low_bits_zero: assert property ( // see [RULE5]
    @(posedge clk_in) disable iff (!resetn_in)
    (reg_rd_in && addr_hit)
    |=> (reg_rdata_out[1:0] == 2'b00))
    else $error("unused bits not zero");
  a_rdata_hold: assert property ( // see [RULE14]
    @(posedge clk_in) disable iff (!resetn_in)
    !(reg_rd_in && addr_hit)
    |=> $stable(reg_rdata_out))
    else $error("read data changed without read");
  c_error_entry: cover property (@(posedge clk_in)
    !port1_fault_state_out ##1 port1_fault_state_out);
  c_write_recover: cover property (@(posedge clk_in)
    port1_fault_state_out && wr_clr ##1 !port1_fault_state_out);
  c_read_clear: cover property (@(posedge clk_in)
    reg_rd_done_in && |rd_clr);
  c_auto_recover: cover property (@(posedge clk_in)
    port1_fault_state_out && auto_recover_in ##1 !port1_fault_state_out);
  c_disable_exit: cover property (@(posedge clk_in)
    port1_fault_state_out && !port1_power_enable_in
    ##1 !port1_fault_state_out);
endmodule : port1_fault_status_logic

// File: testbench/status_host.sv
module status_host
  import fault_status_pkg::*;
(
  input  wire logic [7:0] rdata_in,
  input  wire logic       clk_in,
  output logic [7:0]      addr_out,
  output logic            wr_out,
  output logic [7:0]      wdata_out,
  output logic            rd_out,
  output logic            done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Register access, driven on falling edges
  initial
  begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    {wr_out, rd_out, done_out} = 3'b000;
  end
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    d = rdata_in;
    done_out = 1'b1;
    @(negedge clk_in);
    done_out = 1'b0;
  endtask : rd
  task automatic wr(input logic [7:0] d);
    @(negedge clk_in);
    addr_out = FAULT_EVENT_FLAGS_ADDR;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    wdata_out = ~d;
  endtask : wr
endmodule : status_host

// File: testbench/tb.sv
module tb
  import fault_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_in = 1'b0;
  logic       resetn_in, auto_recover_in, port1_power_enable_in;
  logic       power_enable_control_in, discharge_fail_in, vbus_low_in;
  logic       overtemp_in, overvolt_in, reg_wr_in, reg_rd_in;
  logic       reg_rd_done_in, port1_fault_state_out;
  logic       alert1_n_out, alert2_n_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, rd_v;
  int         n_mismatch = 0;
  int         comparisons = 0;
  always #2 clk_in = ~clk_in;
  port1_fault_status_logic DUT (.clk_in, .resetn_in, .reg_addr_in,
    .reg_wr_in, .reg_wdata_in, .reg_rd_in, .reg_rd_done_in,
    .auto_recover_in, .port1_power_enable_in, .power_enable_control_in,
    .discharge_fail_in, .vbus_low_in, .overtemp_in, .overvolt_in,
    .reg_rdata_out, .port1_fault_state_out, .alert1_n_out, .alert2_n_out);
  status_host host (.rdata_in(reg_rdata_out), .clk_in, .addr_out(reg_addr_in),
    .wr_out(reg_wr_in), .wdata_out(reg_wdata_in), .rd_out(reg_rd_in),
    .done_out(reg_rd_done_in));
  // ==========================================================
  // Checks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] exp);
    host.rd(FAULT_EVENT_FLAGS_ADDR, rd_v);
    chk(rd_v, exp);
  endtask : rchk
  // Expected {state, alert1_n, alert2_n}
  task automatic pins(input logic [2:0] exp);
    repeat (2) @(negedge clk_in);
    chk({5'h00, port1_fault_state_out, alert1_n_out, alert2_n_out},
        {5'h00, exp});
  endtask : pins
  task automatic test_done;
    $display("n_mismatch=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // ==========================================================
  // Sequence
  initial
  begin
    {auto_recover_in, discharge_fail_in, vbus_low_in} = 3'b000;
    {overtemp_in, overvolt_in, power_enable_control_in} = 3'b000;
    port1_power_enable_in = 1'b1;
    resetn_in = 1'b0;
    repeat (2) @(negedge clk_in);
    resetn_in = 1'b1;
    pins(3'b011);
    host.rd(8'h07, rd_v);
    chk(rd_v, 8'h20);
    rchk(8'h20);
    rchk(8'h00);
    discharge_fail_in = 1'b1;
    pins(3'b101);
    rchk(8'hc0);
    host.wr(8'h00);
    discharge_fail_in = 1'b0;
    rchk(8'hc0);
    rchk(8'h80);
    host.wr(8'h00);
    rchk(8'h00);
    vbus_low_in = 1'b1;
    pins(3'b101);
    vbus_low_in = 1'b0;
    port1_power_enable_in = 1'b0;
    rchk(8'h00);
    port1_power_enable_in = 1'b1;
    overtemp_in = 1'b1;
    pins(3'b100);
    rchk(8'h88);
    overtemp_in = 1'b0;
    rchk(8'h88);
    auto_recover_in = 1'b1;
    pins(3'b011);
    overvolt_in = 1'b1;
    pins(3'b100);
    rchk(8'h84);
    overvolt_in = 1'b0;
    resetn_in = 1'b0;
    @(negedge clk_in);
    resetn_in = 1'b1;
    // Toggle only after the edge detector has seen the idle level
    @(negedge clk_in);
    power_enable_control_in = 1'b1;
    rchk(8'h00);
    test_done();
  end
endmodule : tb
